/* rtl/lpw_ctrl.sv */
// Low-power wait/stop controller: clock gating, wake-up and restart delay.
// Assumes CPU opcode strobes and acknowledges are on core_clk; both
// interrupt pins are asynchronous, active low and externally pulled up.
// Operation
// - Maskable pin is low-level, wired-OR shared.
// - Flag holds request until software clears it.
// - Wait opcode stacks registers, then suspends CPU.
// - Oscillator keeps running throughout wait.
// - CPU clock off during whole wait.
// - Wait repeats reads at stacked condition address.
// - Any unmasked interrupt ends wait.
// - Timer stops only if masked and watchdog off.
// - Serial clocks follow their own enable bits.
// - Stop enters only when stop-disable clear.
// - Stop halts every clock including oscillator.
// - All 192 RAM bytes kept in low power.
// - Pin low, reset or edge pending ends stop.
// - Maskable pin wakes stop only when unmasked.
// - Non-maskable pin always wakes stop.
// - Masked non-maskable wake resumes without service.
// - Interrupt wake resumes; reset wake reinitialises.
// - Restart delay on stop exit unless disabled.
// - Reset sets the delay-enable bit.
// - Delay at power-on, not warm reset.
// - Reset sets both interrupt masks.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lpw_ctrl
  import lpw_pkg::*;
#(
  parameter int NUM_INT = NUM_INT_DEF,
  parameter int RESTART_CYCLES = RESTART_CYCLES_DEF
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic powerOnReset,
  input wire lpw_avreq_t avReq,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic waitOpcode,
  input wire logic stopOpcode,
  input wire logic stackDone,
  input wire logic [15:0] stackedCcrAddr,
  input wire logic irqAck,
  input wire logic [NUM_INT-1:0] intEvent,
  input wire logic irqPinN,
  input wire logic extNonmaskableIntPinN,
  output logic stackReq,
  output logic dummyRead,
  output logic [15:0] dummyReadAddr,
  output logic irqRequest,
  output logic xirqRequest,
  output logic resumePulse,
  output logic stopIgnored,
  output logic ramRetain,
  output lpw_gate_t clkGate
);
  // ==========================================================
  // State
  typedef struct packed {
    lpw_mode_t mode;
    logic [CNT_W-1:0] dlyCnt;
    logic irqS1;
    logic irqS2;
    logic irqPrev;
    logic xirqS1;
    logic xirqS2;
    logic edgePend;
    logic [5:0] ctrl;
    logic sBit;
    logic xBit;
    logic iBit;
    logic [NUM_INT-1:0] flags;
    logic [NUM_INT-1:0] inten;
    logic ack;
    logic [31:0] rdata;
    logic resume;
    logic nop;
    logic [15:0] rdAddr;
  } lpw_state_t;

  localparam logic [CNT_W-1:0] DLY_LOAD = CNT_W'(RESTART_CYCLES - 1);

  lpw_state_t s;
  lpw_state_t next_s;
  logic [NUM_INT-1:0] next_flags;
  logic irqLow;
  logic xirqLow;
  logic intPending;
  logic irqLevelReq;
  logic anyWaitWake;
  logic stopWake;
  logic wrEff;
  logic rdEff;

  // ==========================================================
  // Interrupt flags: an event in the clearing cycle survives.
  genvar g;
  generate
    for (g = 0; g < NUM_INT; g++)
    begin : gFlag
      assign next_flags[g] = intEvent[g] |
        (s.flags[g] & ~(wrEff && avReq.address == OFS_FLAG && avReq.writedata[g]));
    end
  endgenerate

  assign irqLow = ~s.irqS2;
  assign xirqLow = ~s.xirqS2;
  assign intPending = |(s.flags & s.inten);
  assign irqLevelReq = (~s.ctrl[CTRL_EDGE] & irqLow) | s.edgePend;
  assign anyWaitWake = (~s.iBit & (irqLevelReq | intPending)) | (~s.xBit & xirqLow);
  assign stopWake = (~s.iBit & irqLevelReq) | xirqLow;
  assign rdEff = avReq.read & s.ack;
  assign wrEff = avReq.write & s.ack;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.irqS1 = irqPinN;
    next_s.irqS2 = s.irqS1;
    next_s.xirqS1 = extNonmaskableIntPinN;
    next_s.xirqS2 = s.xirqS1;
    next_s.irqPrev = s.irqS2;
    next_s.flags = next_flags;
    next_s.resume = 1'b0;
    next_s.nop = 1'b0;
    next_s.ack = (avReq.read | avReq.write) & ~s.ack;
    if (s.ctrl[CTRL_EDGE] && s.irqPrev && !s.irqS2)
    begin
      next_s.edgePend = 1'b1;
    end
    else if (irqAck)
    begin
      next_s.edgePend = 1'b0;
    end
    if (avReq.read && !s.ack)
    begin
      case (avReq.address)
        OFS_CTRL: next_s.rdata = {26'h0000000, s.ctrl};
        OFS_CCR: next_s.rdata = {24'h000000, s.sBit, s.xBit, 1'b0, s.iBit, 4'h0};
        OFS_FLAG: next_s.rdata = 32'(s.flags);
        OFS_INTEN: next_s.rdata = 32'(s.inten);
        OFS_STATUS: next_s.rdata = {26'h0000000, s.xirqS2, s.irqS2, s.edgePend, s.mode};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    if (wrEff)
    begin
      case (avReq.address)
        OFS_CTRL: next_s.ctrl = avReq.writedata[5:0];
        OFS_CCR:
        begin
          next_s.sBit = avReq.writedata[CCR_S];
          next_s.iBit = avReq.writedata[CCR_I];
          // The non-maskable mask can only be cleared once reset has set it.
          next_s.xBit = s.xBit & avReq.writedata[CCR_X];
        end
        OFS_INTEN: next_s.inten = avReq.writedata[NUM_INT-1:0];
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    case (s.mode)
      LPW_RUN:
      begin
        if (waitOpcode)
        begin
          next_s.mode = LPW_STACK;
          next_s.rdAddr = stackedCcrAddr;
        end
        else if (stopOpcode && !s.sBit)
        begin
          next_s.mode = LPW_STOP;
        end
        else if (stopOpcode)
        begin
          next_s.nop = 1'b1;
        end
      end
      LPW_STACK:
      begin
        if (stackDone)
        begin
          next_s.mode = LPW_WAIT;
        end
      end
      LPW_WAIT:
      begin
        if (anyWaitWake)
        begin
          next_s.mode = LPW_RUN;
          next_s.resume = 1'b1;
        end
      end
      LPW_STOP:
      begin
        if (stopWake && s.ctrl[CTRL_DLY])
        begin
          next_s.mode = LPW_RESTART;
          next_s.dlyCnt = DLY_LOAD;
        end
        else if (stopWake)
        begin
          next_s.mode = LPW_RUN;
          next_s.resume = 1'b1;
        end
      end
      LPW_RESTART:
      begin
        if (s.dlyCnt == '0)
        begin
          next_s.mode = LPW_RUN;
          next_s.resume = 1'b1;
        end
        else
        begin
          next_s.dlyCnt = s.dlyCnt - CNT_W'(1);
        end
      end
      default: next_s.mode = LPW_RUN;
    endcase
    if (rst)
    begin
      next_s = '0;
      next_s.irqS1 = 1'b1;
      next_s.irqS2 = 1'b1;
      next_s.irqPrev = 1'b1;
      next_s.xirqS1 = 1'b1;
      next_s.xirqS2 = 1'b1;
      next_s.ctrl = CTRL_RESET;
      next_s.sBit = RESET_S;
      next_s.xBit = RESET_X;
      next_s.iBit = RESET_I;
      // A cold start waits for the oscillator; a warm reset does not.
      next_s.mode = powerOnReset ? LPW_RESTART : LPW_RUN;
      next_s.dlyCnt = DLY_LOAD;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || ce)
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = (avReq.read | avReq.write) & ~s.ack;
  assign stackReq = (s.mode == LPW_STACK);
  assign dummyRead = (s.mode == LPW_WAIT);
  assign dummyReadAddr = s.rdAddr;
  // A masked non-maskable wake raises no request, so execution simply resumes.
  assign irqRequest = ~s.iBit & (irqLevelReq | intPending) & (s.mode == LPW_RUN);
  assign xirqRequest = ~s.xBit & xirqLow & (s.mode == LPW_RUN);
  assign resumePulse = s.resume;
  assign stopIgnored = s.nop;
  // RAM contents depend only on supply, so hold its writes in every mode but run, stacking included.
  assign ramRetain = (s.mode != LPW_RUN);
  always_comb
  begin
    clkGate.cpu = (s.mode == LPW_RUN) || (s.mode == LPW_STACK);
    clkGate.osc = (s.mode != LPW_STOP);
    clkGate.periph = (s.mode != LPW_STOP) && (s.mode != LPW_RESTART);
    clkGate.timer = clkGate.periph &&
      !((s.mode == LPW_WAIT) && s.iBit && s.ctrl[CTRL_WDDIS]);
    clkGate.spi = clkGate.periph && ((s.mode != LPW_WAIT) || s.ctrl[CTRL_SPE]);
    clkGate.uartTx = clkGate.periph && ((s.mode != LPW_WAIT) || s.ctrl[CTRL_TXE]);
    clkGate.uartRx = clkGate.periph && ((s.mode != LPW_WAIT) || s.ctrl[CTRL_RXE]);
  end
endmodule // lpw_ctrl
`default_nettype wire

/* rtl/lpw_pkg.sv */
// Constants and types shared by the low-power wait/stop controller.
// Assumes a single 50 MHz core clock and a byte-addressed Avalon-MM slave.
package lpw_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CCR = 5'h04;
  localparam logic [4:0] OFS_FLAG = 5'h08;
  localparam logic [4:0] OFS_INTEN = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  // ==========================================================
  // Control register fields
  localparam int CTRL_DLY = 0;
  localparam int CTRL_WDDIS = 1;
  localparam int CTRL_SPE = 2;
  localparam int CTRL_TXE = 3;
  localparam int CTRL_RXE = 4;
  localparam int CTRL_EDGE = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  // ==========================================================
  // Condition code mask fields
  localparam int CCR_I = 4;
  localparam int CCR_X = 6;
  localparam int CCR_S = 7;
  localparam logic RESET_S = 1'b1;
  localparam logic RESET_X = 1'b1;
  localparam logic RESET_I = 1'b1;
  // ==========================================================
  // Counts
  localparam int NUM_INT_DEF = 4;
  localparam int RESTART_CYCLES_DEF = 256;
  localparam int CNT_W = 16;
  localparam int RAM_BYTES = 192;

  typedef enum logic [2:0] {LPW_RUN, LPW_STACK, LPW_WAIT, LPW_STOP, LPW_RESTART} lpw_mode_t;

  typedef struct packed {
    logic cpu;
    logic osc;
    logic timer;
    logic spi;
    logic uartTx;
    logic uartRx;
    logic periph;
  } lpw_gate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } lpw_avreq_t;
endpackage

/* verif/lpw_ctrl_props.sv */
// Port checker for the wait/stop controller.
// Bound into every lpw_ctrl instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lpw_ctrl_props
  import lpw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire lpw_avreq_t avReq,
  input wire logic avs_waitrequest,
  input wire logic waitOpcode,
  input wire logic stopOpcode,
  input wire logic [15:0] stackedCcrAddr,
  input wire logic stackReq,
  input wire logic dummyRead,
  input wire logic [15:0] dummyReadAddr,
  input wire logic irqRequest,
  input wire logic xirqRequest,
  input wire logic resumePulse,
  input wire logic stopIgnored,
  input wire logic ramRetain,
  input wire lpw_gate_t clkGate
);
  logic [15:0] capAddr;
  always_ff @(posedge core_clk)
  begin
    if (waitOpcode && !ramRetain)
    begin
      capAddr <= stackedCcrAddr;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !ce);
  // ==========================================================
  // Assertions
  AST_WAIT_GATES: assert property (dummyRead |-> !clkGate.cpu && clkGate.osc && ramRetain)
    else $error("wait gating wrong");
  AST_STOP_ALL_OFF: assert property (!clkGate.osc |-> !clkGate.cpu && !clkGate.timer && !clkGate.periph)
    else $error("clock left running in stop");
  AST_STOP_GATE: assert property (stopOpcode && !ramRetain |=> stopIgnored != ramRetain)
    else $error("stop opcode handled wrongly");
  AST_STACK_FIRST: assert property (waitOpcode && !ramRetain |=> stackReq && !dummyRead)
    else $error("no stacking after wait opcode");
  AST_WAIT_ADDR: assert property (dummyRead |-> dummyReadAddr == capAddr)
    else $error("wait read address wrong");
  AST_RESUME_RUN: assert property (resumePulse |-> !ramRetain && clkGate.cpu && clkGate.osc)
    else $error("resume without running clocks");
  AST_REQ_IN_RUN: assert property (irqRequest || xirqRequest |-> clkGate.cpu)
    else $error("request outside run");
  AST_ONE_WAIT: assert property ($rose(avReq.read || avReq.write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing wrong");
endmodule // lpw_ctrl_props
bind lpw_ctrl lpw_ctrl_props props (.*);
`default_nettype wire

/* verif/lpw_cpu_model.sv */
// CPU core and interrupt pin model facing the controller.
// Assumes pins are pulled up, so a released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module lpw_cpu_model (
  input wire logic core_clk,
  input wire logic stackReq,
  input wire logic [3:0] lat,
  input wire logic [1:0] pullIrq,
  input wire logic pullXirq,
  output logic stackDone,
  output logic irqPinN,
  output logic extNonmaskableIntPinN
);
  int cnt = 0;
  // Open-drain sources share the pin, so any one pulling wins.
  assign irqPinN = ~|pullIrq;
  assign extNonmaskableIntPinN = ~pullXirq;
  always_ff @(posedge core_clk)
  begin
    cnt <= stackReq ? cnt + 1 : 0;
    stackDone <= stackReq && cnt == int'(lat);
  end
endmodule // lpw_cpu_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the wait/stop controller.
// Assumes the Avalon slave answers after its own wait state.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lpw_pkg::*;
;
  localparam int RC = 6;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, powerOnReset = 1'b1, irqAck = 1'b0;
  logic waitOpcode = 1'b0, stopOpcode = 1'b0, pullXirq = 1'b0;
  logic [15:0] stackedCcrAddr = 16'h0, dummyReadAddr;
  logic [3:0] intEvent = 4'h0, lat = 4'h0;
  logic [1:0] pullIrq = 2'h0;
  lpw_avreq_t avReq = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, stackReq, stackDone, dummyRead, irqRequest, xirqRequest;
  logic resumePulse, stopIgnored, ramRetain, irqPinN, extNonmaskableIntPinN;
  lpw_gate_t clkGate;
  int n_errors = 0, checked = 0;
  lpw_ctrl #(.RESTART_CYCLES(RC)) dut (.*);
  lpw_cpu_model cpu (.*);
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  // ==========================================================
  // Tasks
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avReq <= '{a, !w, w, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    chk("bus answer", 32'(n < 50), 32'h1);
  endtask
  task automatic await(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 100)
    begin
      @(posedge core_clk);
      k++;
    end
    chk("handshake", 32'(k < 100), 32'h1);
  endtask
  // Counts restart cycles: oscillator up while the core clock is still held.
  task automatic cpuOff(output int n);
    int k;
    n = 0;
    k = 0;
    while (clkGate.cpu !== 1'b1 && k < 200)
    begin
      @(posedge core_clk);
      k++;
      if (clkGate.osc === 1'b1 && clkGate.cpu === 1'b0) n++;
    end
  endtask
  task automatic stop();
    @(posedge core_clk);
    stopOpcode <= 1'b1;
    @(posedge core_clk);
    stopOpcode <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    logic [31:0] q, r;
    int n;
    void'($urandom(72161));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    cpuOff(n);
    chk("power-on delay", n, RC);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk("ctrl reset", q, 32'h1);
    bus(1'b0, OFS_CCR, 32'h0, q);
    chk("ccr masks", q & 32'hD0, 32'hD0);
    bus(1'b0, 5'h14, 32'h0, q);
    chk("unmapped", q, 32'h0);
    stop();
    chk("stop refused", clkGate.osc, 32'h1);
    bus(1'b1, OFS_CCR, 32'h50, q);
    stop();
    pullIrq <= 2'h2;
    repeat (10) @(posedge core_clk);
    chk("masked pin", clkGate.osc, 32'h0);
    pullXirq <= 1'b1;
    cpuOff(n);
    chk("restart delay", n, RC);
    @(posedge core_clk);
    chk("masked nmi", xirqRequest, 32'h0);
    pullIrq <= 2'h0;
    pullXirq <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      r = ($urandom & 32'h1E) | (k << 1);
      bus(1'b1, OFS_CTRL, r, q);
      bus(1'b1, OFS_CCR, k ? 32'h10 : 32'h0, q);
      bus(1'b1, OFS_INTEN, 32'h1, q);
      waitOpcode <= 1'b1;
      stackedCcrAddr <= 16'($urandom);
      lat <= 4'($urandom);
      @(posedge core_clk);
      waitOpcode <= 1'b0;
      await(dummyRead);
      chk("wait addr", dummyReadAddr, stackedCcrAddr);
      chk("spi gate", clkGate.spi, r[2]);
      chk("tx gate", clkGate.uartTx, r[3]);
      chk("rx gate", clkGate.uartRx, r[4]);
      chk("timer gate", clkGate.timer, !k);
      chk("cpu gate", {clkGate.cpu, clkGate.osc}, 32'h1);
      if (k) pullXirq <= 1'b1;
      else intEvent <= 4'h1;
      @(posedge core_clk);
      intEvent <= 4'h0;
      await(resumePulse);
      repeat (2) @(posedge core_clk);
      chk("irq request", irqRequest, !k);
      chk("nmi request", xirqRequest, k);
      bus(1'b1, OFS_FLAG, 32'h1, q);
      pullXirq <= 1'b0;
      @(posedge core_clk);
      chk("request dropped", irqRequest, 32'h0);
    end
    bus(1'b1, OFS_CCR, 32'h0, q);
    stop();
    pullIrq <= 2'h1;
    cpuOff(n);
    chk("no delay", n, 32'h0);
    pullIrq <= 2'h0;
    bus(1'b1, OFS_CTRL, 32'h20, q);
    stop();
    pullIrq <= 2'h2;
    cpuOff(n);
    chk("edge wake", n, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("edge pending", q & 32'h8, 32'h8);
    irqAck <= 1'b1;
    @(posedge core_clk);
    irqAck <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("edge cleared", q & 32'h8, 32'h0);
    pullIrq <= 2'h0;
    rst <= 1'b1;
    powerOnReset <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("warm reset", clkGate.cpu, 32'h1);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk("ctrl again", q, 32'h1);
    print_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
